// ===== design/wdw_cfg.svh
// Constants of the watchdog block: register offsets, field positions,
// reset values and timing counts, shared by the package and the modules.
// Assumes an 8-bit register map reached over a plain strobe port.
// How it works
// [R01] Warning sets flag even when interrupt masked.
// [R02] Mask set/clear by writing ones; zeros ignored.
// [R03] Request holds while flag and mask set.
// [R04] All requests ORed onto one line.
// [R05] Software reads flags to find the cause.
// [R06] Warning request usable as asynchronous wake source.
// [R07] Enable write crosses over; busy until done.
// [R08] Restart writes cross over before acting.
// [R09] Locked-running keeps counter going despite enable.
// [R10] Locked-running bit clears only on power-on.
// [R11] Locked-running freezes period and warning setups.
// [R12] Window bit writable when disabled or locked.
// [R13] Locked-running still allows window and mask writes.
// [R14] Window bit and mask pick four modes; the code picks the mode from the window bit and running only.
// [R15] Normal mode warns after delay-field cycles.
// [R16] Delay not shorter than period: time-out first.
// [R17] Window mode warns when open window starts.
// [R18] Enable writable only while not locked-running.
// [R19] Control bits load from nonvolatile row.
// [R20] Codes 0..0xB give 8..16384 cycles, doubling.
// [R21] Key 0xa5 restarts; other values reset.
// [R22] Early restart in closed window resets.
// [R23] Writing one clears the warning flag.
// [R24] Time-out reset is one registered pulse.
`ifndef WDW_CFG_SVH
`define WDW_CFG_SVH

`define WDW_OFS_CONTROL   4'h0
`define WDW_OFS_PERIOD    4'h1
`define WDW_OFS_DELAY     4'h2
`define WDW_OFS_MASK_CLR  4'h4
`define WDW_OFS_MASK_SET  4'h5
`define WDW_OFS_FLAGS     4'h6
`define WDW_OFS_PENDING   4'h8
`define WDW_OFS_RESTART   4'hc

`define WDW_BIT_ENABLE    1
`define WDW_BIT_WINDOW    2
`define WDW_BIT_LOCKED    7
`define WDW_BIT_WARN      0
`define WDW_BIT_PEND_EN   1
`define WDW_BIT_PEND_CLR  4

`define WDW_RST_MASK      1'b0
`define WDW_RST_FLAG      1'b0
`define WDW_RST_CODE      4'h0

`define WDW_RESTART_KEY   8'ha5
`define WDW_SYNC_TICKS    2'h2
`define WDW_BASE_CYCLES   17'h00008
`define WDW_MAX_PER_CODE  4'hb
`define WDW_MAX_DLY_CODE  4'ha

`endif

// ===== design/wdw_pkg.sv
// Types of the watchdog block.
// Assumes wdw_cfg.svh sits on the include path.
`include "wdw_cfg.svh"

package wdw_pkg;

  // Operating mode as seen by the counter.
  typedef enum logic [1:0] {
    WDW_STOPPED = 2'b00,
    WDW_NORMAL  = 2'b01,
    WDW_WINDOW  = 2'b10
  } wdw_mode_t;

  typedef logic [3:0]  wdw_code_t;
  typedef logic [16:0] wdw_span_t;

endpackage

// ===== design/wdw_tick_sync.sv
// Brings the slow watchdog oscillator into the system clock domain and
// turns each of its rising edges into a one-cycle tick.
// Assumes the oscillator is far slower than the system clock.
`timescale 1ns/1ps

module wdw_tick_sync
  import wdw_pkg::*;
(
  // Clock and reset.
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  // Oscillator pin and tick out.
  input  wire logic i_osc,
  output logic      o_tick
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic tick;
  } wdw_sync_t;

  wdw_sync_t s_q;
  wdw_sync_t s_d;

  // The first stage feeds only the second; the edge detector sees stage two.
  always_comb begin
    s_d      = s_q;
    s_d.meta = i_osc;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
    s_d.tick = s_q.sync & ~s_q.prev;
  end

  // State register.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;

endmodule // wdw_tick_sync

// ===== design/wdw_top.sv
// Watchdog with early warning, mask and flag handling, crossing of enable
// and restart writes, and the locked-running mode.
// Assumes i_reset is the power-on reset and i_warm_reset a later system reset.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "wdw_cfg.svh"

module wdw_top
  import wdw_pkg::*;
(
  // Clock and resets.
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_warm_reset,
  // Watchdog oscillator pin.
  input  wire logic        i_osc,
  // Start-up values from the nonvolatile row.
  input  wire logic        i_nvm_enable,
  input  wire logic        i_nvm_window,
  input  wire logic        i_nvm_locked,
  input  wire logic [3:0]  i_nvm_period,
  input  wire logic [3:0]  i_nvm_closed,
  input  wire logic [3:0]  i_nvm_delay,
  // Register port.
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Interrupt request and reset request.
  output logic             o_irq,
  output logic             o_wdt_reset
);

  typedef struct packed {
    logic        loaded;
    logic        locked;
    logic        en;
    logic        wen;
    logic        en_wd;
    wdw_code_t   timeout_select;
    wdw_code_t   win;
    wdw_code_t   dly;
    logic        mask;
    logic        flag;
    logic        busy_en;
    logic        busy_clr;
    logic [7:0]  key;
    logic [1:0]  sync_cnt;
    logic [16:0] cnt;
    logic        rst_pulse;
    logic [31:0] rdata;
  } wdw_state_t;

  wdw_state_t s_q;
  wdw_state_t s_d;
  logic       tick;

  // Cycles of the oscillator for a code, reserved codes held at the top one.
  function automatic wdw_span_t span_of(input wdw_code_t c, input wdw_code_t lim);
    wdw_code_t k;
    k = (c > lim) ? lim : c;
    span_of = `WDW_BASE_CYCLES << k;
  endfunction

  wdw_tick_sync u_tick (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_osc     (i_osc),
    .o_tick    (tick)
  );

  // Decoded strobes of the register port.
  logic wr_ctrl;
  logic wr_per;
  logic wr_dly;
  logic wr_mclr;
  logic wr_mset;
  logic wr_flag;
  logic wr_key;
  assign wr_ctrl = i_wr && (i_addr == `WDW_OFS_CONTROL);
  assign wr_per  = i_wr && (i_addr == `WDW_OFS_PERIOD);
  assign wr_dly  = i_wr && (i_addr == `WDW_OFS_DELAY);
  assign wr_mclr = i_wr && (i_addr == `WDW_OFS_MASK_CLR);
  assign wr_mset = i_wr && (i_addr == `WDW_OFS_MASK_SET);
  assign wr_flag = i_wr && (i_addr == `WDW_OFS_FLAGS);
  assign wr_key  = i_wr && (i_addr == `WDW_OFS_RESTART);

  // Counter timing derived from the current setup.
  wdw_mode_t mode;
  wdw_span_t closed_len;
  wdw_span_t open_len;
  wdw_span_t warn_at;
  wdw_span_t tmo_at;
  logic      running;
  logic      apply;
  logic      key_good;
  logic      too_early;
  logic      ew_evt;
  logic      tmo_evt;

  // Locked-running keeps the count going whatever the enable says.
  assign running    = s_q.locked | s_q.en_wd;                          // [R09]
  // The running state and the window bit pick stopped, normal or window mode.
  assign mode       = !running ? WDW_STOPPED : (s_q.wen ? WDW_WINDOW : WDW_NORMAL); // [R14]
  assign closed_len = span_of(s_q.win, `WDW_MAX_PER_CODE);              // [R20]
  assign open_len   = span_of(s_q.timeout_select, `WDW_MAX_PER_CODE);              // [R20]
  // Window mode warns as the open window starts, whatever the delay field.
  assign warn_at    = (mode == WDW_WINDOW) ? closed_len                 // [R17]
                      : span_of(s_q.dly, `WDW_MAX_DLY_CODE);            // [R15]
  assign tmo_at     = (mode == WDW_WINDOW) ? 17'(closed_len + open_len) : open_len;
  // A crossing finishes once the wanted number of oscillator ticks passed.
  assign apply      = tick && (s_q.sync_cnt == `WDW_SYNC_TICKS - 2'h1)
                      && (s_q.busy_en || s_q.busy_clr);                 // [R07] [R08]
  assign key_good   = (s_q.key == `WDW_RESTART_KEY);
  assign too_early  = (mode == WDW_WINDOW) && (17'(s_q.cnt + 17'h1) <= closed_len);
  // Time-out fires on the count's last tick; a later warning never comes.
  // Greater-or-equal also ends a count left beyond a period shortened by a mode switch.
  assign tmo_evt    = (mode != WDW_STOPPED) && tick && (17'(s_q.cnt + 17'h1) >= tmo_at);
  assign ew_evt     = (mode != WDW_STOPPED) && tick && !tmo_evt         // [R16]
                      && (17'(s_q.cnt + 17'h1) == warn_at);

  // Next state of the whole block.
  always_comb begin
    s_d           = s_q;
    s_d.rst_pulse = 1'b0;
    s_d.rdata     = '0;

    // Load the control and setup fields from the nonvolatile row.
    if (!s_q.loaded || i_warm_reset) begin
      s_d.loaded = 1'b1;
      s_d.locked = s_q.locked | i_nvm_locked;                          // [R19] [R10]
      s_d.en     = i_nvm_enable;                                        // [R19]
      s_d.en_wd  = i_nvm_enable;
      s_d.wen    = i_nvm_window;                                        // [R19]
      s_d.timeout_select    = i_nvm_period;
      s_d.win    = i_nvm_closed;
      s_d.dly    = i_nvm_delay;
      s_d.mask   = `WDW_RST_MASK;
      s_d.flag   = `WDW_RST_FLAG;
      s_d.busy_en  = 1'b0;
      s_d.busy_clr = 1'b0;
      s_d.sync_cnt = '0;
      s_d.cnt      = '0;
    end else begin
      // Control register writes.
      if (wr_ctrl) begin
        if (!s_q.locked) begin
          s_d.en      = i_wdata[`WDW_BIT_ENABLE];                       // [R18]
          s_d.busy_en = 1'b1;                                           // [R07]
          s_d.sync_cnt = '0;
        end
        if (!s_q.en || s_q.locked) begin
          s_d.wen = i_wdata[`WDW_BIT_WINDOW];                           // [R12] [R13]
        end
        // Writing zero never clears locked-running.
        if (!s_q.en && i_wdata[`WDW_BIT_LOCKED]) begin
          s_d.locked = 1'b1;                                            // [R10]
        end
      end
      // Setup registers freeze while enabled or locked.
      if (wr_per && !s_q.en && !s_q.locked) begin                       // [R11]
        s_d.timeout_select = i_wdata[3:0];
        s_d.win = i_wdata[7:4];
      end
      if (wr_dly && !s_q.en && !s_q.locked) begin                       // [R11]
        s_d.dly = i_wdata[3:0];
      end
      // Mask set and clear stay usable in every mode.
      if (wr_mset && i_wdata[`WDW_BIT_WARN]) begin
        s_d.mask = 1'b1;                                                // [R02] [R13]
      end
      if (wr_mclr && i_wdata[`WDW_BIT_WARN]) begin
        s_d.mask = 1'b0;                                                // [R02] [R13]
      end
      // Restart key is held until the crossing completes.
      if (wr_key) begin
        s_d.key      = i_wdata[7:0];                                    // [R08]
        s_d.busy_clr = 1'b1;
        s_d.sync_cnt = '0;
      end

      // Crossing progress counted in oscillator ticks.
      if (tick && (s_q.busy_en || s_q.busy_clr) && !wr_ctrl && !wr_key) begin
        s_d.sync_cnt = 2'(s_q.sync_cnt + 2'h1);
      end

      // Counter in the watchdog time base.
      if (!running) begin
        s_d.cnt = '0;
      end else if (tick) begin
        s_d.cnt = 17'(s_q.cnt + 17'h1);
      end
      if (tmo_evt) begin
        s_d.cnt       = '0;
        s_d.rst_pulse = 1'b1;                                           // [R24]
      end

      // Finish a crossing: hand over the enable and act on the key.
      if (apply && !wr_ctrl && !wr_key) begin
        s_d.sync_cnt = '0;
        if (s_q.busy_en) begin
          s_d.en_wd   = s_q.en;                                         // [R07]
          s_d.busy_en = 1'b0;
        end
        if (s_q.busy_clr) begin
          s_d.busy_clr = 1'b0;
          s_d.cnt      = '0;
          if (!key_good || too_early) begin
            s_d.rst_pulse = 1'b1;                                       // [R21] [R22]
          end
        end
      end

      // Warning flag: a write of one clears, a new event wins over it.
      if (wr_flag && i_wdata[`WDW_BIT_WARN]) begin
        s_d.flag = 1'b0;                                                // [R23]
      end
      if (ew_evt) begin
        s_d.flag = 1'b1;                                                // [R01]
      end
    end

    // Read data stand in the cycle after the strobe only.
    if (i_rd) begin
      unique case (i_addr)
        `WDW_OFS_CONTROL:  begin
          s_d.rdata[`WDW_BIT_LOCKED] = s_q.locked;
          s_d.rdata[`WDW_BIT_WINDOW] = s_q.wen;
          s_d.rdata[`WDW_BIT_ENABLE] = s_q.en;
        end
        `WDW_OFS_PERIOD:   s_d.rdata[7:0] = {s_q.win, s_q.timeout_select};
        `WDW_OFS_DELAY:    s_d.rdata[3:0] = s_q.dly;
        `WDW_OFS_MASK_CLR,
        `WDW_OFS_MASK_SET: s_d.rdata[`WDW_BIT_WARN] = s_q.mask;
        `WDW_OFS_FLAGS:    s_d.rdata[`WDW_BIT_WARN] = s_q.flag;         // [R05]
        `WDW_OFS_PENDING:  begin
          s_d.rdata[`WDW_BIT_PEND_EN]  = s_q.busy_en;                   // [R07]
          s_d.rdata[`WDW_BIT_PEND_CLR] = s_q.busy_clr;
        end
        default:           s_d.rdata = '0;
      endcase
    end
  end

  // State register; the nonvolatile load happens in the first cycle after.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // One request line; it is pure gating of registers, so it needs no clock
  // edge to assert and can wake the system.
  assign o_irq       = s_q.flag & s_q.mask;                             // [R03] [R04] [R06]
  assign o_wdt_reset = s_q.rst_pulse;
  assign o_rdata     = s_q.rdata;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  sequence s_restart_done;
    apply && s_q.busy_clr && !wr_ctrl && !wr_key && s_q.loaded && !i_warm_reset;
  endsequence

  sequence s_warn_fire;
    ew_evt && s_q.loaded && !i_warm_reset;
  endsequence

  sequence s_enable_done;
    apply && s_q.busy_en && !wr_ctrl && !wr_key && s_q.loaded && !i_warm_reset;
  endsequence

  // Flag and request behaviour.
  a_warn_sets_flag: assert property (s_warn_fire |=> s_q.flag) // [R01]
    else $error("Warning event did not set the flag.");
  a_flag_clear: assert property (s_q.loaded && !i_warm_reset && wr_flag // [R23]
    && i_wdata[`WDW_BIT_WARN] && !ew_evt |=> !s_q.flag)
    else $error("Flag clear write did not clear.");
  a_irq_rises: assert property (s_warn_fire ##0 (s_q.mask && !wr_mclr) // [R03]
    |=> o_irq)
    else $error("Enabled warning gave no request.");
  a_irq_holds: assert property (o_irq && !wr_flag && !wr_mclr && !i_warm_reset // [R03]
    |=> o_irq)
    else $error("Request dropped without a cause.");

  // Mask set and clear.
  a_mask_set_one: assert property (s_q.loaded && !i_warm_reset && wr_mset // [R02]
    && i_wdata[0] |=> s_q.mask)
    else $error("Mask set write did not enable.");
  a_mask_clear_one: assert property (s_q.loaded && !i_warm_reset && wr_mclr // [R02]
    && i_wdata[0] |=> !s_q.mask)
    else $error("Mask clear write did not disable.");

  // Control protection and locked-running.
  a_locked_sticky: assert property (s_q.locked |=> s_q.locked) // [R10]
    else $error("Locked-running bit was cleared.");
  a_setup_frozen: assert property (s_q.locked && !i_warm_reset // [R11]
    |=> $stable(s_q.timeout_select) && $stable(s_q.win) && $stable(s_q.dly))
    else $error("Setup changed while locked-running.");
  a_enable_locked: assert property (s_q.loaded && !i_warm_reset && s_q.locked // [R18]
    && wr_ctrl |=> $stable(s_q.en))
    else $error("Enable changed while locked-running.");
  a_window_guard: assert property (s_q.loaded && !i_warm_reset && s_q.en // [R12]
    && !s_q.locked && wr_ctrl |=> $stable(s_q.wen))
    else $error("Window bit changed while enabled.");
  a_window_locked: assert property (s_q.loaded && !i_warm_reset && s_q.locked // [R13]
    && wr_ctrl |=> s_q.wen == $past(i_wdata[`WDW_BIT_WINDOW]))
    else $error("Window bit not writable while locked-running.");

  // Crossings of enable and restart writes.
  a_enable_busy: assert property (s_q.loaded && !i_warm_reset && wr_ctrl // [R07]
    && !s_q.locked |=> s_q.busy_en)
    else $error("Enable write did not raise busy.");
  a_enable_handover: assert property (s_enable_done // [R07]
    |=> s_q.en_wd == $past(s_q.en) && !s_q.busy_en)
    else $error("Enable crossing did not hand over.");
  a_restart_busy: assert property (s_q.loaded && !i_warm_reset && wr_key // [R08]
    |=> s_q.busy_clr)
    else $error("Restart write did not raise busy.");

  // Restart outcome and time-out pulse.
  a_good_restart: assert property (s_restart_done // [R21]
    ##0 (key_good && !too_early && !tmo_evt) |=> !o_wdt_reset && s_q.cnt == 17'h0)
    else $error("Valid restart did not clear the count.");
  a_bad_key_reset: assert property (s_restart_done ##0 !key_good // [R21]
    |=> o_wdt_reset)
    else $error("Wrong key did not reset.");
  a_early_restart: assert property (s_restart_done ##0 too_early // [R22]
    |=> o_wdt_reset)
    else $error("Early restart did not reset.");
  a_timeout_pulse: assert property (tmo_evt && s_q.loaded && !i_warm_reset // [R24]
    |=> o_wdt_reset)
    else $error("Time-out gave no reset request.");
  a_pulse_single: assert property (o_wdt_reset |=> !o_wdt_reset) // [R24]
    else $error("Reset request longer than one cycle.");

  // Counter progress.
  a_stopped_clear: assert property (!running |=> s_q.cnt == 17'h0) // [R09]
    else $error("Counter moved while stopped.");
  a_locked_counts: assert property (s_q.locked && s_q.loaded && tick && !tmo_evt // [R09]
    && !apply && !i_warm_reset |=> s_q.cnt == 17'($past(s_q.cnt) + 17'h1))
    else $error("Counter stalled while locked-running.");

endmodule // wdw_top

// ===== verif/testbench.sv
// Self-checking bench for the watchdog top: register map, warning timing, restart and lock.
// Assumes the design package, its modules and wdw_cfg.svh are compiled ahead of this file.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module testbench;
  logic        i_clk_sys = 1'b0;
  logic        i_reset, i_warm_reset, i_osc, i_wr, i_rd;
  logic        i_nvm_enable, i_nvm_window, i_nvm_locked;
  logic [3:0]  i_nvm_period, i_nvm_closed, i_nvm_delay, i_addr;
  logic [31:0] i_wdata, o_rdata, v;
  logic        o_irq, o_wdt_reset;
  logic        rst_prev = 1'b0;
  logic        irq_prev = 1'b0;
  logic [7:0]  m_ctl, m_cfg, m_msk;
  logic [3:0]  m_dly;
  int          num_errors = 0, checked = 0, osc_n = 0, rst_n = 0, rst_at = 0, irq_at = -1, r;

  wdw_top dut_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_warm_reset(i_warm_reset),
    .i_osc(i_osc), .i_nvm_enable(i_nvm_enable), .i_nvm_window(i_nvm_window),
    .i_nvm_locked(i_nvm_locked), .i_nvm_period(i_nvm_period), .i_nvm_closed(i_nvm_closed),
    .i_nvm_delay(i_nvm_delay), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_irq(o_irq), .o_wdt_reset(o_wdt_reset));

  // Makes the 5 ns system clock.
  always #2.5 i_clk_sys = ~i_clk_sys;

  // Runs the watchdog oscillator, one edge every four system cycles.
  always begin
    repeat (4) @(posedge i_clk_sys);
    i_osc <= ~i_osc;
  end

  // Counts oscillator periods so timing is judged in watchdog ticks.
  always @(posedge i_osc) osc_n++;

  // Records reset pulses and rising interrupt edges between clock edges.
  always @(negedge i_clk_sys) begin
    if (o_wdt_reset === 1'b1) begin
      `CHK("reset_width", 1'b0, rst_prev)
      rst_n++;
      rst_at = osc_n;
    end
    if (o_irq === 1'b1 && irq_prev !== 1'b1) irq_at = osc_n;
    rst_prev = o_wdt_reset;
    irq_prev = o_irq;
  end

  // Expected read data from the register model.
  function automatic logic [31:0] exp_rd(input int a);
    case (a)
      0: return {24'h0, m_ctl};
      1: return {24'h0, m_cfg};
      2: return {28'h0, m_dly};
      4, 5: return {24'h0, m_msk};
      default: return 32'h0;
    endcase
  endfunction

  // One write cycle; the model follows the protection of each field.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic en, lk;
    en = m_ctl[1];
    lk = m_ctl[7];
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
    case (a)
      4'h0: begin
        if (!en || lk) m_ctl[2] = d[2];
        if (!lk) m_ctl[1] = d[1];
        if (!en && !lk) m_ctl[7] = d[7];
      end
      4'h1: if (!en && !lk) m_cfg = d[7:0];
      4'h2: if (!en && !lk) m_dly = d[3:0];
      4'h4: m_msk[0] = m_msk[0] & ~d[0];
      4'h5: m_msk[0] = m_msk[0] | d[0];
      default: ;
    endcase
  endtask

  // One read cycle; data is taken in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // Reads every readable offset except the flags at 6, gaps included, against the model.
  task automatic chk_all;
    for (int a = 0; a < 9; a++) begin
      if (a != 6) begin
        rd(a[3:0], v);
        `CHK("reg_read", exp_rd(a), v)
      end
    end
  endtask

  // Waits until both crossings report done.
  task automatic poll;
    int k;
    k = 0;
    do begin
      rd(4'h8, v);
      k++;
    end while ((v[1] | v[4]) !== 1'b0 && k < 40);
    `CHK("sync_busy", 32'h0, v)
  endtask

  // Waits, with a bound, for the next reset pulse.
  task automatic wait_rst;
    int n0, k;
    n0 = rst_n;
    k = 0;
    while (rst_n == n0 && k < 1000) begin
      @(posedge i_clk_sys);
      k++;
    end
    `CHK("reset_wait", 1'b1, rst_n != n0)
  endtask

  // Measures one whole period and the warning inside it, in ticks.
  task automatic prd(input int timeout_select, input int warn);
    int r0;
    wait_rst();
    r0 = rst_at;
    wr(4'h6, 32'h1);
    irq_at = -1;
    wait_rst();
    `CHK("period", timeout_select, rst_at - r0)
    `CHK("warning", warn, (irq_at < 0) ? -1 : irq_at - r0)
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Cuts a hang short well after the expected run length.
  initial begin
    #250000;
    num_errors++;
    test_done();
  end

  // Main sequence of tests.
  initial begin
    void'($urandom(96));
    {i_reset, i_warm_reset, i_osc, i_wr, i_rd} = 5'b10000;
    {i_nvm_enable, i_nvm_window, i_nvm_locked} = 3'b000;
    i_nvm_period = 4'h2;
    i_nvm_closed = 4'($urandom % 12);
    i_nvm_delay = 4'h1;
    i_addr = 4'h0;
    i_wdata = 32'h0;
    m_ctl = 8'h00;
    m_cfg = {i_nvm_closed, 4'h2};
    m_dly = 4'h1;
    m_msk = 8'h00;
    repeat (3) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    chk_all();
    repeat (6) wr(4'h4 + 4'($urandom % 2), $urandom);
    chk_all();
    note("registers");
    wr(4'h0, 32'h02);
    poll();
    wr(4'h5, 32'h1);
    prd(32, 16);
    wr(4'h0, 32'h06);
    wr(4'h1, $urandom);
    poll();
    chk_all();
    note("normal");
    wr(4'h4, 32'h1);
    wr(4'h6, 32'h1);
    wait_rst();
    wait_rst();
    rd(4'h6, v);
    `CHK("flag_masked", 32'h1, v)
    `CHK("irq_masked", 1'b0, o_irq)
    wr(4'h5, 32'h1);
    `CHK("irq_on", 1'b1, o_irq)
    wr(4'h6, 32'h0);
    `CHK("irq_zero_write", 1'b1, o_irq)
    wr(4'h6, 32'h1);
    `CHK("irq_cleared", 1'b0, o_irq)
    note("flags");
    wait_rst();
    r = rst_n;
    repeat (160) @(posedge i_clk_sys);
    wr(4'hc, 32'ha5);
    repeat (200) @(posedge i_clk_sys);
    `CHK("key_restart", r, rst_n)
    wait_rst();
    v = $urandom % 256;
    if (v == 32'ha5) v = 32'h5a;
    r = rst_n;
    wr(4'hc, v);
    repeat (60) @(posedge i_clk_sys);
    `CHK("bad_key", r + 1, rst_n)
    note("restart");
    wr(4'h0, 32'h00);
    poll();
    wr(4'h2, 32'h3);
    wr(4'h0, 32'h02);
    poll();
    chk_all();
    prd(32, -1);
    note("late_warning");
    wr(4'h0, 32'h00);
    poll();
    wr(4'h0, 32'h04);
    wr(4'h1, 32'h12);
    wr(4'h2, 32'h1);
    wr(4'h0, 32'h06);
    poll();
    chk_all();
    prd(48, 16);
    wait_rst();
    r = rst_n;
    wr(4'hc, 32'ha5);
    repeat (60) @(posedge i_clk_sys);
    `CHK("early_restart", r + 1, rst_n)
    note("window");
    wr(4'h0, 32'h04);
    poll();
    wr(4'h0, 32'h84);
    poll();
    chk_all();
    prd(48, 16);
    wr(4'h0, 32'h02);
    wr(4'h1, $urandom);
    wr(4'h2, $urandom);
    wr(4'h4, 32'h1);
    wr(4'h5, 32'h1);
    poll();
    chk_all();
    prd(32, 16);
    @(posedge i_clk_sys);
    i_warm_reset <= 1'b1;
    @(posedge i_clk_sys);
    i_warm_reset <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    m_ctl = 8'h80;
    m_cfg = {i_nvm_closed, 4'h2};
    m_dly = 4'h1;
    m_msk = 8'h00;
    chk_all();
    @(posedge i_clk_sys);
    i_reset <= 1'b1;
    {i_nvm_enable, i_nvm_window} <= 2'b11;
    repeat (3) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    m_ctl = 8'h06;
    chk_all();
    note("locked");
    test_done();
  end
endmodule // testbench
